// file: hw/dbrw_ctrl.v
// Host-side DDR2 column burst controller with an AHB-Lite register port.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dbrw_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Read command is CS and CAS low, RAS and WE high, column on address.
// - Write command is CS, CAS and WE low, RAS high, column on address.
// - Write latency is AL + CL - 1 clocks from command to first strobe edge.
// - Controller drives the strobe low as preamble one clock before write latency.
// - Controller puts write bits on successive strobe edges until four or eight.
// - Write recovery must pass between write burst end and bank precharge.
// - Write may follow read after four clocks (burst four) or six (burst eight).
// - Gapless reads come every two clocks (burst four) or four (burst eight).
// - Read interruption only by a read, burst eight, exactly two clocks later.
// - A read with auto-precharge must never be interrupted.
// - An interrupting read may target any bank.
// - Command spacing always uses the programmed burst length.
// - Column commands are at least two clocks apart.
// - Column commands go only to activated banks.
module dbrw_ctrl (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // Activation state kept by the row logic
    input wire [3:0] bank_open,
    // Memory clock and command pins
    output wire ck,
    output wire ck_n,
    output wire cs_n,
    output wire ras_n,
    output wire cas_n,
    output wire we_n,
    output wire [1:0] ba,
    output wire [12:0] addr,
    // Data and strobe pins
    input wire [15:0] dq_in,
    output wire [15:0] dq_out,
    output wire dq_oe_n,
    input wire dqs_in,
    output wire dqs_out,
    output wire dqs_oe_n,
    output wire dqs_n_out,
    output wire dqs_n_oe_n
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_CMD = 4'b0010;
    localparam [3:0] ST_WRT = 4'b0100;
    localparam [3:0] ST_RDT = 4'b1000;

    // Half-tick count of a latency given in clocks.
    function [5:0] half;
        input [4:0] clocks;
        begin
            half = {clocks, 1'b0};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    reg [3:0] state_q;
    reg [2:0] ph_q;
    reg ck_q;
    reg [5:0] ht_q;
    reg [5:0] gap_rd_q;
    reg [5:0] gap_wr_q;
    reg pend_q;
    reg wr_q;
    reg [1:0] ba_q;
    reg [9:0] col_q;
    reg [8:0] mode_q;
    reg done_q;
    reg err_q;
    reg tmo_q;
    reg [15:0] dbuf_q [0:7];
    reg cs_n_q;
    reg ras_n_q;
    reg cas_n_q;
    reg we_n_q;
    reg [1:0] ba_o_q;
    reg [12:0] addr_q;
    reg [15:0] dq_q;
    reg dq_oe_n_q;
    reg dqs_q;
    reg dqs_oe_n_q;
    reg dqs_s1_q;
    reg dqs_s2_q;
    reg dqs_s3_q;
    reg [15:0] dq_s1_q;
    reg [15:0] dq_s2_q;
    reg cap_q;
    reg [3:0] rc_q;
    reg wv_q;
    reg [5:0] wa_q;
    reg [31:0] hrdata_q;
    reg [31:0] rmux;

    // Latencies in half clock periods, taken from the mode copy.
    wire [4:0] rl = {2'b00, mode_q[`DBRW_MODE_AL]} + {2'b00, mode_q[`DBRW_MODE_CL]};
    wire [5:0] rl2 = half(rl);
    wire [5:0] wl2 = rl2 - `DBRW_CK_HT;
    wire bl8 = mode_q[`DBRW_MODE_BL8];
    wire [5:0] blh = bl8 ? `DBRW_BL8_HT : `DBRW_BL4_HT;
    wire [5:0] wk = ht_q - wl2 + `DBRW_ONE_HT;
    wire [2:0] beat = (state_q == ST_WRT) ? wk[2:0] : rc_q[2:0];
    wire [2:0] slot;
    wire stb_ph = (ph_q == `DBRW_PH_STB0) || (ph_q == `DBRW_PH_STB1);
    wire dat_ph = (ph_q == `DBRW_PH_DAT0) || (ph_q == `DBRW_PH_DAT1);
    wire half_edge = (ph_q == `DBRW_PH_RISE) || (ph_q == `DBRW_PH_FALL);
    wire acc = hsel & hready & htrans[1];
    wire wcmd = wv_q && (wa_q == `DBRW_A_CMD);
    wire go = wcmd && hwdata[`DBRW_CMD_GO];
    wire wstat = wv_q && (wa_q == `DBRW_A_STAT);
    wire gap_ok = ht_q >= (wr_q ? gap_wr_q : gap_rd_q);
    wire rd_open = ht_q >= (rl2 - `DBRW_ONE_HT);
    wire dqs_edge = dqs_s2_q ^ dqs_s3_q;
    wire set_done = ((state_q == ST_WRT) && stb_ph && (ht_q == wl2 + blh + `DBRW_ONE_HT))
        || ((state_q == ST_RDT) && cap_q && (rc_q + 4'h1 == blh[3:0]));
    wire set_tmo = (state_q == ST_RDT) && (ht_q == rl2 + blh + `DBRW_RD_SLACK_HT) && !cap_q;
    wire set_err = (go && (pend_q || state_q != ST_IDLE))
        || (pend_q && state_q == ST_IDLE && ph_q == `DBRW_PH_FALL && gap_ok && !bank_open[ba_q]);

    dbrw_order u_order (
        .start(col_q[2:0]),
        .bl8(bl8),
        .ilv(mode_q[`DBRW_MODE_ILV]),
        .beat(beat),
        .idx(slot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus read mux and register writes.
    always @* begin
        rmux = 32'h0;
        if (haddr[`DBRW_A_DATA_BIT]) begin
            rmux = {16'h0, dbuf_q[haddr[4:2]]};
        end else begin
            case (haddr[5:0])
                `DBRW_A_CMD: rmux = {28'h0, ba_q, wr_q, pend_q};
                `DBRW_A_COL: rmux = {22'h0, col_q};
                `DBRW_A_MODE: rmux = {23'h0, mode_q};
                `DBRW_A_STAT: rmux = {28'h0, tmo_q, err_q, done_q, state_q != ST_IDLE || pend_q};
                default: rmux = 32'h0;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wv_q <= 1'b0;
            wa_q <= 6'h00;
            hrdata_q <= 32'h0;
            col_q <= 10'h000;
            mode_q <= `DBRW_MODE_RST;
            done_q <= 1'b0;
            err_q <= 1'b0;
            tmo_q <= 1'b0;
        end else begin
            wv_q <= acc & hwrite;
            if (acc) begin
                wa_q <= haddr[5:0];
            end
            if (acc && !hwrite) begin
                hrdata_q <= rmux;
            end
            if (wv_q && wa_q == `DBRW_A_COL) begin
                col_q <= hwdata[9:0];
            end
            if (wv_q && wa_q == `DBRW_A_MODE) begin
                mode_q <= hwdata[8:0];
            end
            // A hardware set in the clearing cycle wins.
            done_q <= set_done | (done_q & ~(wstat & hwdata[`DBRW_ST_DONE]));
            err_q <= set_err | (err_q & ~(wstat & hwdata[`DBRW_ST_ERR]));
            tmo_q <= set_tmo | (tmo_q & ~(wstat & hwdata[`DBRW_ST_TMO]));
        end
    end

    // Data buffer: software fills it for writes, the read capture fills it for reads.
    always @(posedge mclk) begin
        if (state_q == ST_RDT && cap_q) begin
            dbuf_q[slot] <= dq_s2_q;
        end else if (wv_q && wa_q[`DBRW_A_DATA_BIT]) begin
            dbuf_q[wa_q[4:2]] <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the read strobe and data.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dqs_s1_q <= 1'b1;
            dqs_s2_q <= 1'b1;
            dqs_s3_q <= 1'b1;
            dq_s1_q <= 16'h0;
            dq_s2_q <= 16'h0;
        end else begin
            dqs_s1_q <= dqs_in;
            dqs_s2_q <= dqs_s1_q;
            dqs_s3_q <= dqs_s2_q;
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory clock, command sequencing and burst data.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            ph_q <= 3'h0;
            ck_q <= 1'b1;
            ht_q <= `DBRW_HT_MAX;
            gap_rd_q <= 6'h00;
            gap_wr_q <= 6'h00;
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            ba_q <= 2'b00;
            cs_n_q <= 1'b1;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            we_n_q <= 1'b1;
            ba_o_q <= 2'b00;
            addr_q <= 13'h0000;
            dq_q <= 16'h0;
            dq_oe_n_q <= 1'b1;
            dqs_q <= 1'b0;
            dqs_oe_n_q <= 1'b1;
            cap_q <= 1'b0;
            rc_q <= 4'h0;
        end else begin
            ph_q <= ph_q + 3'h1;
            ck_q <= ~ph_q[2] ^ (ph_q == `DBRW_PH_RISE) ^ (ph_q == `DBRW_PH_FALL);
            cap_q <= 1'b0;
            if (half_edge && ht_q != `DBRW_HT_MAX) begin
                ht_q <= ht_q + 6'h01;
            end
            if (go && !pend_q && state_q == ST_IDLE) begin
                pend_q <= 1'b1;
                wr_q <= hwdata[`DBRW_CMD_WR];
                ba_q <= hwdata[`DBRW_CMD_BA];
            end
            if (ph_q == `DBRW_PH_FALL) begin
                cs_n_q <= 1'b1;
                ras_n_q <= 1'b1;
                cas_n_q <= 1'b1;
                we_n_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    // Commands change on the falling memory clock so they are stable at the rise.
                    if (pend_q && ph_q == `DBRW_PH_FALL && gap_ok) begin
                        pend_q <= 1'b0;
                        if (bank_open[ba_q]) begin
                            cs_n_q <= 1'b0;
                            ras_n_q <= 1'b1;
                            cas_n_q <= 1'b0;
                            we_n_q <= ~wr_q;
                            ba_o_q <= ba_q;
                            addr_q <= {3'b000, col_q};
                            state_q <= ST_CMD;
                        end
                    end
                end
                ST_CMD: begin
                    if (ph_q == `DBRW_PH_RISE) begin
                        ht_q <= 6'h00;
                        rc_q <= 4'h0;
                        // Spacing uses the programmed length; no read is ever cut short.
                        if (wr_q) begin
                            gap_rd_q <= wl2 + blh + `DBRW_WTR_HT;
                            gap_wr_q <= wl2 + blh + `DBRW_WTR_HT;
                            state_q <= ST_WRT;
                        end else begin
                            gap_rd_q <= blh;
                            gap_wr_q <= bl8 ? `DBRW_RTW8_HT : `DBRW_RTW4_HT;
                            state_q <= ST_RDT;
                        end
                    end
                end
                ST_WRT: begin
                    if (stb_ph) begin
                        if (ht_q == wl2 - `DBRW_CK_HT) begin
                            dqs_oe_n_q <= 1'b0;
                            dqs_q <= 1'b0;
                        end else if (ht_q >= wl2 && ht_q < wl2 + blh) begin
                            dqs_q <= ~ht_q[0];
                        end else if (ht_q == wl2 + blh) begin
                            dqs_q <= 1'b0;
                        end else if (ht_q == wl2 + blh + `DBRW_ONE_HT) begin
                            dqs_oe_n_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                    // Data changes midway between strobe edges to centre it on them.
                    if (dat_ph) begin
                        if (ht_q >= wl2 - `DBRW_ONE_HT && ht_q < wl2 + blh - `DBRW_ONE_HT) begin
                            dq_oe_n_q <= 1'b0;
                            dq_q <= dbuf_q[slot];
                        end else if (ht_q == wl2 + blh - `DBRW_ONE_HT) begin
                            dq_oe_n_q <= 1'b1;
                        end
                    end
                end
                ST_RDT: begin
                    // The window opens at the preamble, so the first edge seen must rise.
                    if (dqs_edge && rd_open && rc_q < blh[3:0] && (rc_q != 4'h0 || dqs_s2_q)) begin
                        cap_q <= 1'b1;
                    end
                    if (cap_q) begin
                        rc_q <= rc_q + 4'h1;
                        if (rc_q + 4'h1 == blh[3:0]) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (set_tmo) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign ck = ck_q;
    assign ck_n = ~ck_q;
    assign cs_n = cs_n_q;
    assign ras_n = ras_n_q;
    assign cas_n = cas_n_q;
    assign we_n = we_n_q;
    assign ba = ba_o_q;
    assign addr = addr_q;
    assign dq_out = dq_q;
    assign dq_oe_n = dq_oe_n_q;
    assign dqs_out = dqs_q;
    assign dqs_oe_n = dqs_oe_n_q;
    // The complement strobe is only driven when the differential mode is set.
    assign dqs_n_out = ~dqs_q;
    assign dqs_n_oe_n = dqs_oe_n_q | ~mode_q[`DBRW_MODE_DIFF];
endmodule // dbrw_ctrl
`default_nettype wire

// file: hw/dbrw_order.v
// Burst beat to column offset mapping for sequential and interleaved order.
`timescale 1ns/1ps
`default_nettype none
module dbrw_order (
    // Burst setup
    input wire [2:0] start,
    input wire bl8,
    input wire ilv,
    // Beat in, column offset out
    input wire [2:0] beat,
    output reg [2:0] idx
);
    always @* begin
        if (ilv) begin
            idx = {start[2] ^ (bl8 & beat[2]), start[1:0] ^ beat[1:0]};
        end else begin
            idx = {start[2] ^ (bl8 & beat[2]), start[1:0] + beat[1:0]};
        end
    end
endmodule // dbrw_order
`default_nettype wire

// file: hw/dbrw_regs.vh
// Register map, field positions and timing constants of the DDR2 burst controller.
`ifndef DBRW_REGS_VH
`define DBRW_REGS_VH
`define DBRW_A_CMD 6'h00
`define DBRW_A_COL 6'h04
`define DBRW_A_MODE 6'h08
`define DBRW_A_STAT 6'h0c
`define DBRW_A_DATA_BIT 5
`define DBRW_CMD_GO 0
`define DBRW_CMD_WR 1
`define DBRW_CMD_BA 3:2
`define DBRW_MODE_CL 2:0
`define DBRW_MODE_AL 5:3
`define DBRW_MODE_BL8 6
`define DBRW_MODE_ILV 7
`define DBRW_MODE_DIFF 8
`define DBRW_MODE_RST 9'h013
`define DBRW_ST_BUSY 0
`define DBRW_ST_DONE 1
`define DBRW_ST_ERR 2
`define DBRW_ST_TMO 3
`define DBRW_PH_RISE 3'h7
`define DBRW_PH_FALL 3'h3
`define DBRW_PH_STB0 3'h0
`define DBRW_PH_STB1 3'h4
`define DBRW_PH_DAT0 3'h2
`define DBRW_PH_DAT1 3'h6
`define DBRW_HT_MAX 6'h3f
`define DBRW_BL4_HT 6'h04
`define DBRW_BL8_HT 6'h08
`define DBRW_RTW4_HT 6'h08
`define DBRW_RTW8_HT 6'h0c
`define DBRW_WTR_HT 6'h04
`define DBRW_RD_SLACK_HT 6'h08
`define DBRW_ONE_HT 6'h01
`define DBRW_CK_HT 6'h02
`endif

// file: sim/dbrw_ctrl_sva.sv
// Checker for the command and write-strobe pins of the DDR2 burst controller.
`timescale 1ns/1ps
`default_nettype none
module dbrw_ctrl_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Command side
    input wire logic [3:0] bank_open,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    // Write data side
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic dqs_out,
    input wire logic dqs_oe_n,
    input wire logic dqs_n_out,
    input wire logic dqs_n_oe_n
);
    ////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [5:0] gap_q;
    logic rd_q;
    // The gap saturates, so a long idle spell never wraps into a false short one.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 6'h3f;
            rd_q <= 1'b0;
        end else if ($fell(cs_n)) begin
            gap_q <= 6'h0;
            rd_q <= we_n;
        end else if (gap_q != 6'h3f) begin
            gap_q <= gap_q + 6'h1;
        end
    end
    sequence cmd_hold_s;
        (!cs_n)[*8] ##1 cs_n;
    endsequence
    sequence wr_pre_s;
        (!dqs_out && !dqs_oe_n)[*8] ##1 dqs_out;
    endsequence
    cmd_hold_a: assert property ($fell(cs_n) |-> cmd_hold_s)
        else $error("command not held one clock");
    cmd_code_a: assert property (!cs_n |-> ras_n && !cas_n && addr[12:10] == 3'h0)
        else $error("bad column command code");
    cmd_edge_a: assert property ($fell(cs_n) |-> $fell(ck))
        else $error("command not launched at clock fall");
    open_bank_a: assert property ($fell(cs_n) |-> bank_open[ba])
        else $error("command to closed bank");
    col_gap_a: assert property ($fell(cs_n) |-> gap_q >= 6'd15)
        else $error("column commands too close");
    rd_wr_a: assert property ($fell(cs_n) && !we_n && rd_q |-> gap_q >= 6'd31)
        else $error("write too soon after read");
    preamble_a: assert property ($fell(dqs_oe_n) |-> wr_pre_s)
        else $error("write preamble wrong");
    pre_phase_a: assert property ($fell(dqs_oe_n) |-> $past(ck) && !$past(ck, 2))
        else $error("preamble not after clock rise");
    data_hold_a: assert property (!dq_oe_n && $changed(dqs_out) |-> $stable(dq_out))
        else $error("write data moves at strobe edge");
    oe_pair_a: assert property (!dq_oe_n |-> !dqs_oe_n)
        else $error("data driven without strobe");
    diff_a: assert property (!dqs_n_oe_n |-> !dqs_oe_n && dqs_n_out == !dqs_out)
        else $error("complement strobe wrong");
endmodule // dbrw_ctrl_sva
bind dbrw_ctrl dbrw_ctrl_sva u_dbrw_ctrl_sva (.mclk(mclk), .rst_n(rst_n),
    .bank_open(bank_open), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .dqs_n_out(dqs_n_out),
    .dqs_n_oe_n(dqs_n_oe_n));
`default_nettype wire

// file: sim/dbrw_dev.sv
// Behavioural model of the DDR2 device on the far side of the controller.
`timescale 1ns/1ps
`default_nettype none
module dbrw_dev (
    // Command pins
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    // Resolved wires and programmed mode
    input wire logic [15:0] dq_w,
    input wire logic dqs_w,
    input wire logic [2:0] cl,
    input wire logic [2:0] al,
    input wire logic bl8,
    input wire logic ilv,
    // Device drive, inverted last value when released
    output logic [15:0] dq_m,
    output logic dqs_m
);
    ////////////////////////////////////////////////////////////
    logic [15:0] mem [0:4095];
    initial begin
        dq_m = 16'h0;
        dqs_m = 1'b1;
    end
    function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] k);
        ord = ilv ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
    endfunction
    // Edges past the burst length are never sampled.
    task automatic burst(input logic rd, input logic [11:0] c);
        int k;
        if (rd) begin
            repeat (al + cl - 1) @(posedge ck);
            dqs_m = 1'b0;
            @(posedge ck);
            for (k = 0; k < (bl8 ? 8 : 4); k++) begin
                if (k > 0) @(ck);
                dqs_m = ~k[0];
                dq_m = mem[{c[11:3], ord(c[2:0], k[2:0])}];
            end
            @(ck);
            dqs_m = 1'b1;
            dq_m = ~dq_m;
        end else begin
            @(posedge dqs_w);
            for (k = 0; k < (bl8 ? 8 : 4); k++) begin
                if (k > 0) @(dqs_w);
                mem[{c[11:3], ord(c[2:0], k[2:0])}] = dq_w;
            end
        end
    endtask
    always @(posedge ck) begin
        if (!cs_n && ras_n && !cas_n) begin
            fork
                burst(we_n, {ba, addr[9:0]});
            join_none
        end
    end
endmodule // dbrw_dev
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the DDR2 burst controller.
`timescale 1ns/1ps
`default_nettype none
`include "dbrw_regs.vh"
module tb;
    ////////////////////////////////////////////////////////////
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] bank_open = 4'hf;
    logic [2:0] cl = 3'h3;
    logic [2:0] al = 3'h2;
    logic bl8 = 1'b0;
    logic ilv = 1'b0;
    wire hreadyout, hresp, ck, ck_n, cs_n, ras_n, cas_n, we_n, dqs_m;
    wire dq_oe_n, dqs_out, dqs_oe_n, dqs_n_out, dqs_n_oe_n;
    wire [31:0] hrdata;
    wire [1:0] ba;
    wire [12:0] addr;
    wire [15:0] dq_out, dq_m;
    wire [15:0] dq_bus = !dq_oe_n ? dq_out : dq_m;
    wire dqs_bus = !dqs_oe_n ? dqs_out : dqs_m;
    int failures = 0;
    int n_tests = 0;
    int i, m;
    logic [63:0] expq [$];
    logic [31:0] wd [8];
    logic [31:0] r;
    logic [11:0] c;
    always #20 mclk = ~mclk;
    dbrw_ctrl u_dbrw_ctrl (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .bank_open(bank_open), .ck(ck), .ck_n(ck_n), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_bus),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_in(dqs_bus), .dqs_out(dqs_out),
        .dqs_oe_n(dqs_oe_n), .dqs_n_out(dqs_n_out), .dqs_n_oe_n(dqs_n_oe_n));
    dbrw_dev u_dbrw_dev (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .dq_w(dq_bus), .dqs_w(dqs_bus), .cl(cl), .al(al),
        .bl8(bl8), .ilv(ilv), .dq_m(dq_m), .dqs_m(dqs_m));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] k);
        if (k == 32'h0) return;
        n_tests++;
        if ((got & k) !== (exp & k)) begin
            failures++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Read results are matched in issue order as they leave the data phase.
    always @(posedge mclk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            check(hrdata, expq[0][31:0], expq[0][63:32]);
            void'(expq.pop_front());
        end
    end
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic [31:0] k);
        if (!wr) expq.push_back({k, exp});
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {26'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
        rd_ph <= 1'b0;
    endtask
    task automatic wait_end(input logic [31:0] exp);
        do bus(1'b0, `DBRW_A_STAT, 0, 0, 0); while (r[0] !== 1'b0 || r[3:1] === 3'h0);
        bus(1'b0, `DBRW_A_STAT, 0, exp, 32'he);
        bus(1'b1, `DBRW_A_STAT, 32'he, 0, 0);
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(97769));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, `DBRW_A_MODE, 0, 32'h13, 32'h1ff);
        bus(1'b0, `DBRW_A_STAT, 0, 0, 32'hf);
        bus(1'b0, 6'h10, 0, 0, 0);
        // Every order and length, with random latencies and a random start column.
        for (m = 0; m < 4; m++) begin
            bl8 <= m[0];
            ilv <= m[1];
            cl <= 3'(3 + $urandom % 3);
            al <= 3'($urandom % 3);
            c <= 12'($urandom);
            @(posedge mclk);
            bus(1'b1, `DBRW_A_MODE, {23'h0, 1'($urandom), ilv, bl8, al, cl}, 0, 0);
            for (i = 0; i < 8; i++) begin
                wd[i] = $urandom;
                u_dbrw_dev.mem[{c[11:3], i[2:0]}] = ~wd[i][15:0];
                bus(1'b1, 6'(32 + 4 * i), wd[i], 0, 0);
            end
            bus(1'b1, `DBRW_A_COL, {22'h0, c[9:0]}, 0, 0);
            bus(1'b1, `DBRW_A_CMD, {28'h0, c[11:10], 2'h3}, 0, 0);
            bus(1'b1, `DBRW_A_CMD, {28'h0, c[11:10], 2'h3}, 0, 0);
            wait_end(32'h6);
            for (i = 0; i < 8; i++) begin
                check({16'h0, u_dbrw_dev.mem[{c[11:3], i[2:0]}]},
                      (bl8 || i[2] == c[2]) ? wd[i] : ~wd[i], 32'hffff);
            end
            for (i = 0; i < 8; i++) begin
                wd[i] = $urandom;
                u_dbrw_dev.mem[{c[11:3], i[2:0]}] = wd[i][15:0];
            end
            bus(1'b1, `DBRW_A_CMD, {28'h0, c[11:10], 2'h1}, 0, 0);
            wait_end(32'h2);
            for (i = 0; i < 8; i++) begin
                if (bl8 || i[2] == c[2]) bus(1'b0, 6'(32 + 4 * i), 0, wd[i], 32'hffff);
            end
        end
        bank_open <= 4'h0;
        bus(1'b1, `DBRW_A_CMD, 32'h1, 0, 0);
        wait_end(32'h4);
        bank_open <= 4'hf;
        // A device that answers later than the slack allows must leave only the timeout flag.
        al <= 3'h7;
        bus(1'b1, `DBRW_A_MODE, 32'h3, 0, 0);
        bus(1'b1, `DBRW_A_CMD, 32'h1, 0, 0);
        wait_end(32'h8);
        stop_test();
    end
endmodule // tb
`default_nettype wire
